// *** rtl/supply_reset_supervisor.sv ***
`timescale 1ns/1ps
module supply_reset_supervisor
  import supply_reset_pkg::*;
#(
  parameter logic [9:0] TRIP_CODE = TRIP_CODE_DEFAULT,
  parameter logic [9:0] threshold_hysteresis = HYST_CODE_DEFAULT,
  parameter logic [31:0] HOLD_CYCLES = 32'(HOLD_DEFAULT_CYCLES),
  parameter low_drive_t LOW_DRIVE = DRV_PUSH_PULL
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [9:0] supplyLevel,
  input wire logic manual_reset_n,
  input wire logic watchdogTimeout,
  output logic resetOutN,
  output logic resetOutNOe,
  output logic pullUpEnable,
  output logic resetOut
);
  ////////////////////////////////////////////////////////////////
  logic [9:0] supplyMeta, supplySync;
  logic mrMeta, mrSync, wdMeta, wdSync;
  logic supplyLow, powerUp, anyCause, holdRestart, holdExpired;
  logic [4:0] powerCount;
  seq_state_t state, next_state;
  // release level one bit wider so trip plus hysteresis cannot wrap
  localparam logic [10:0] RELEASE_CODE = 11'(TRIP_CODE) + 11'(threshold_hysteresis);

  // pins come from outside the clock domain; two flops each
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      supplyMeta <= '0;
      supplySync <= '0;
      mrMeta <= 1'b1;
      mrSync <= 1'b1;
      wdMeta <= 1'b0;
      wdSync <= 1'b0;
    end else begin
      supplyMeta <= supplyLevel;
      supplySync <= supplyMeta;
      mrMeta <= manual_reset_n;
      mrSync <= mrMeta;
      wdMeta <= watchdogTimeout;
      wdSync <= wdMeta;
    end
  end
  // a multi-bit code can tear across the sync; comparator hysteresis masks it

  ////////////////////////////////////////////////////////////////
  // hysteresis comparator: trip falling, release only above trip plus hysteresis
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      supplyLow <= 1'b1; // starts low, below minimum the output is moot
    end else if (supplySync < TRIP_CODE) begin
      supplyLow <= 1'b1;
    end else if ({1'b0, supplySync} > RELEASE_CODE) begin
      supplyLow <= 1'b0;
    end
  end

  // power-up in progress for a short settle span after reset
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      powerCount <= '0;
    end else if (powerUp) begin
      powerCount <= powerCount + 5'h01;
    end
  end
  assign powerUp = powerCount != 5'(POWERUP_CYCLES);

  assign anyCause = !mrSync || wdSync || supplyLow || powerUp;
  // any cause keeps the timer cleared so the full delay restarts
  assign holdRestart = anyCause;

  hold_delay_timer #(
    .COUNT_W(32),
    .HOLD_CYCLES(HOLD_CYCLES)
  ) holdTimer (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .restart(holdRestart),
    .expired(holdExpired)
  );

  ////////////////////////////////////////////////////////////////
  // sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      ST_RESET: if (!anyCause) next_state = ST_HOLD;
      ST_HOLD: begin
        if (anyCause) next_state = ST_RESET;
        else if (holdExpired) next_state = ST_RUN;
      end
      ST_RUN: if (anyCause) next_state = ST_RESET;
      default: next_state = ST_RESET;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state <= ST_RESET;
    end else begin
      state <= next_state;
    end
  end

  // outputs registered; asserted one edge after anyCause, without waiting on the state
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      resetOut <= RST_STATE_ACTIVE;
    end else begin
      resetOut <= anyCause || next_state != ST_RUN;
    end
  end

  // low pin: data always 0 for open drain, enable while asserting
  always_comb begin
    resetOutN = !resetOut;
    resetOutNOe = 1'b1;
    pullUpEnable = 1'b0;
    if (LOW_DRIVE != DRV_PUSH_PULL) begin
      resetOutN = 1'b0;
      resetOutNOe = resetOut;
      // save current: pull-up disconnected while pulling low
      pullUpEnable = (LOW_DRIVE == DRV_OPEN_DRAIN_INT_PU) && !resetOut;
    end
  end

  ////////////////////////////////////////////////////////////////
  sequence causeSeen;
    anyCause;
  endsequence
  // a cause followed by its first quiet cycle
  sequence causeGone;
    anyCause ##1 !anyCause;
  endsequence
  // released supply sitting inside the band, or above it
  sequence bandQuiet;
    !supplyLow && supplySync >= TRIP_CODE;
  endsequence

  property causeForces;
    @(posedge core_clk) disable iff (sys_rst) causeSeen |=> resetOut;
  endproperty
  cause_forces_a: assert property (causeForces) else $error("cause without reset");

  // trip is seen by the comparator, then by the output one edge later
  supply_trip_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    supplySync < TRIP_CODE |=> supplyLow ##1 resetOut) else $error("trip missed");

  band_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    supplyLow && {1'b0, supplySync} <= RELEASE_CODE |=> supplyLow)
    else $error("released inside band");

  // noise inside the band must not trip a released supply either
  band_stay_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    bandQuiet |=> !supplyLow) else $error("tripped inside band");

  no_early_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $fell(resetOut) |-> $past(holdExpired)) else $error("released early");

  restart_full_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    causeSeen |=> !holdExpired) else $error("timer not restarted");

  // a rising supply starts nothing until it clears the release level
  rise_wait_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    supplyLow |=> !holdExpired) else $error("timer ran below release");

  release_low_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $fell(resetOut) |-> resetOutNOe == (LOW_DRIVE == DRV_PUSH_PULL))
    else $error("low pin not released");

  // still high one cycle after the first quiet cycle that follows any cause
  high_active_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    causeGone |=> resetOut) else $error("high pin dropped too soon");

  pullup_off_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    resetOut |-> !pullUpEnable) else $error("pull-up on while low");

  // the internal pull-up variant must reconnect once released
  pullup_on_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !resetOut && LOW_DRIVE == DRV_OPEN_DRAIN_INT_PU |-> pullUpEnable)
    else $error("pull-up left off");

  // push-pull low pin always drives, always the inverse of the high pin
  push_pull_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    LOW_DRIVE == DRV_PUSH_PULL |-> resetOutNOe && resetOutN == !resetOut)
    else $error("push-pull low pin wrong");

  // sequencer and output register must agree on the run state
  run_output_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state == ST_RUN) == !resetOut) else $error("output disagrees with state");

  ////////////////////////////////////////////////////////////////
  // quiet-cycle count kept apart from the timer, so the release check
  // does not lean on the counter that it guards
  logic [31:0] quietCount;
  always_ff @(posedge core_clk) begin
    if (sys_rst || anyCause) begin
      quietCount <= '0;
    end else if (quietCount != 32'hFFFFFFFF) begin
      quietCount <= quietCount + 32'h1;
    end
  end

  // release only after a full quiet hold span
  hold_min_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $fell(resetOut) |-> quietCount >= HOLD_CYCLES) else $error("hold span too short");
endmodule

// *** rtl/supply_reset_pkg.sv ***
package supply_reset_pkg;
  // output driver styles for the active-low reset pin
  typedef enum logic [1:0] {
    DRV_PUSH_PULL = 2'h0,
    DRV_OPEN_DRAIN_INT_PU = 2'h1,
    DRV_OPEN_DRAIN_EXT_PU = 2'h2
  } low_drive_t;

  // sequencer states, gray along reset -> hold -> run
  typedef enum logic [1:0] {
    ST_RESET = 2'h0,
    ST_HOLD = 2'h1,
    ST_RUN = 2'h3
  } seq_state_t;

  localparam int unsigned CLK_HZ = 200_000_000;
  // hold delay option figures, microseconds, minimum column
  localparam int unsigned HOLD_MIN_US_1P4MS = 1_000;
  localparam int unsigned HOLD_MIN_US_30MS = 20_000;
  localparam int unsigned HOLD_MIN_US_200MS = 140_000;
  localparam int unsigned HOLD_MIN_US_1P6S = 1_120_000;
  // default option: 200 ms typical, 140 ms guaranteed minimum
  localparam int unsigned HOLD_DEFAULT_US = HOLD_MIN_US_200MS;
  localparam longint unsigned CYCLES_PER_US = CLK_HZ / 1_000_000;
  localparam longint unsigned HOLD_DEFAULT_CYCLES = HOLD_DEFAULT_US * CYCLES_PER_US;
  // power-up settle span after reset release, in cycles
  localparam int unsigned POWERUP_CYCLES = 16;
  localparam logic [9:0] TRIP_CODE_DEFAULT = 10'h200;
  localparam logic [9:0] HYST_CODE_DEFAULT = 10'h010;
  localparam logic RST_STATE_ACTIVE = 1'b1;
endpackage

// *** rtl/hold_delay_timer.sv ***
`timescale 1ns/1ps
module hold_delay_timer
  import supply_reset_pkg::*;
#(
  parameter int unsigned COUNT_W = 32,
  parameter logic [31:0] HOLD_CYCLES = 32'(HOLD_DEFAULT_CYCLES)
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic restart,
  output logic expired
);
  logic [COUNT_W-1:0] count;

  // count up from restart; expired stays high until the next restart
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      count <= '0;
      expired <= 1'b0;
    end else if (restart) begin
      count <= '0;
      expired <= 1'b0;
    end else if (!expired) begin
      if (count == COUNT_W'(HOLD_CYCLES - 32'h1)) begin
        expired <= 1'b1;
      end
      count <= count + COUNT_W'(1);
    end
  end
endmodule

// *** verification/host_reset_input.sv ***
`timescale 1ns/1ps
// host side of the active-low reset pin, with its own view of the wire
module host_reset_input (
  input wire logic core_clk,
  input wire logic resetOutN,
  input wire logic resetOutNOe,
  input wire logic pullUpEnable,
  output logic pinLevel,
  output logic hostInReset
);
  logic lastLevel = 1'b0;
  // a floating pin shows the inverse of its last level, never a stale high
  assign pinLevel = resetOutNOe ? resetOutN : (pullUpEnable ? 1'b1 : ~lastLevel);
  assign hostInReset = ~pinLevel;
  // remembered level for the floating case
  always_ff @(posedge core_clk) begin
    lastLevel <= pinLevel;
  end
endmodule

// *** verification/supply_reset_supervisor_tb_top.sv ***
`timescale 1ns/1ps
module supply_reset_supervisor_tb_top;
  import supply_reset_pkg::*;
  // short hold so the run stays small
  localparam int HOLD = 20;
  typedef struct {logic [9:0] lvl; logic mrn; logic wdt; logic exp;} row_t;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [9:0] supplyLevel = 10'h300;
  logic manual_reset_n = 1'b1;
  logic watchdogTimeout = 1'b0;
  logic resetOutN, resetOutNOe, pullUpEnable, resetOut, pinLevel, hostInReset;
  logic pushLowN, pushLowOe, pushPullUp, pushHigh;
  int num_errors = 0;
  int samples_checked = 0;
  int n;
  // inputs beside the reset level they should give; 0x205 sits in the band
  row_t rows [5] = '{'{10'h1FF, 1'b1, 1'b0, 1'b1}, '{10'h205, 1'b1, 1'b0, 1'b0},
    '{10'h300, 1'b0, 1'b0, 1'b1}, '{10'h300, 1'b1, 1'b1, 1'b1},
    '{10'h000, 1'b1, 1'b0, 1'b1}};
  always #2.5 core_clk = ~core_clk;
  supply_reset_supervisor #(.HOLD_CYCLES(32'(HOLD)), .LOW_DRIVE(DRV_OPEN_DRAIN_INT_PU)) dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .supplyLevel(supplyLevel),
    .manual_reset_n(manual_reset_n), .watchdogTimeout(watchdogTimeout),
    .resetOutN(resetOutN), .resetOutNOe(resetOutNOe), .pullUpEnable(pullUpEnable),
    .resetOut(resetOut));
  host_reset_input host (.core_clk(core_clk), .resetOutN(resetOutN),
    .resetOutNOe(resetOutNOe), .pullUpEnable(pullUpEnable), .pinLevel(pinLevel),
    .hostInReset(hostInReset));
  // push-pull variant on the same inputs, so a second of the three driver styles is seen too
  supply_reset_supervisor #(.HOLD_CYCLES(32'(HOLD)), .LOW_DRIVE(DRV_PUSH_PULL)) dutPush (
    .core_clk(core_clk), .sys_rst(sys_rst), .supplyLevel(supplyLevel),
    .manual_reset_n(manual_reset_n), .watchdogTimeout(watchdogTimeout),
    .resetOutN(pushLowN), .resetOutNOe(pushLowOe), .pullUpEnable(pushPullUp),
    .resetOut(pushHigh));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic check_count(input int got, input int lo, input int hi);
    samples_checked++;
    if (got < lo || got > hi) begin
      num_errors++;
      $display("wrong value at %0t: %0d cycles not in %0d..%0d", $time, got, lo, hi);
    end
  endtask
  task automatic cycles(input int k);
    repeat (k) @(negedge core_clk);
  endtask
  // bounded wait for release; a hang ends the run as a mismatch
  task automatic wait_fall(output int c);
    c = 0;
    while (resetOut !== 1'b0) begin
      @(negedge core_clk);
      c++;
      if (c > 200) begin
        num_errors++;
        $display("wrong value at %0t: release never came", $time);
        close_out();
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    cycles(20);
    sys_rst = 1'b0;
    check_bit(resetOut, 1'b1);
    wait_fall(n);
    check_count(n, 16 + HOLD, 16 + HOLD + 10);
    check_bit(hostInReset, 1'b0);
    check_bit(pullUpEnable, 1'b1);
    check_bit(pushLowN, 1'b1);
    // table of causes plus one in-band quiet row, each followed by a full release
    foreach (rows[i]) begin
      {supplyLevel, manual_reset_n, watchdogTimeout} = {rows[i].lvl, rows[i].mrn, rows[i].wdt};
      cycles(8);
      check_bit(resetOut, rows[i].exp);
      check_bit(resetOutNOe, rows[i].exp);
      check_bit(pullUpEnable, ~rows[i].exp);
      check_bit(hostInReset, rows[i].exp);
      check_bit(pushLowN, ~rows[i].exp);
      check_bit(pushLowOe, 1'b1);
      check_bit(pushPullUp, 1'b0);
      {supplyLevel, manual_reset_n, watchdogTimeout} = {10'h300, 1'b1, 1'b0};
      wait_fall(n);
    end
    // trip, then sit exactly at trip plus hysteresis: no release
    supplyLevel = 10'h1FF;
    cycles(8);
    supplyLevel = 10'h210;
    cycles(40);
    check_bit(resetOut, 1'b1);
    supplyLevel = 10'h211;
    wait_fall(n);
    check_count(n, HOLD, HOLD + 10);
    // a manual press in mid-hold restarts the whole delay
    supplyLevel = 10'h1FF;
    cycles(8);
    supplyLevel = 10'h300;
    cycles(12);
    manual_reset_n = 1'b0;
    cycles(4);
    manual_reset_n = 1'b1;
    wait_fall(n);
    check_count(n, HOLD, HOLD + 10);
    // reset in mid-run: outputs go active on the next rising edge and the power-up span repeats
    sys_rst = 1'b1;
    cycles(2);
    check_bit(resetOut, 1'b1);
    check_bit(pushLowN, 1'b0);
    sys_rst = 1'b0;
    wait_fall(n);
    check_count(n, 16 + HOLD, 16 + HOLD + 10);
    close_out();
  end
endmodule
